// ### src/status_led_and_reset_control.sv
`timescale 1ns/10ps
module status_led_and_reset_control #(
    parameter int unsigned EXT_RESET_CYC =
        led_reset_pkg::EXT_RESET_MS * led_reset_pkg::CLK_KHZ,
    parameter int unsigned INIT_CYC =
        led_reset_pkg::INIT_MS * led_reset_pkg::CLK_KHZ,
    parameter int unsigned POR_INIT_CYC =
        led_reset_pkg::POR_INIT_MS * led_reset_pkg::CLK_KHZ,
    parameter int unsigned FLASH_FAST_EDGES =
        led_reset_pkg::XTAL_FAST_KHZ * 1000 / (2 * led_reset_pkg::FLASH_HZ),
    parameter int unsigned FLASH_SLOW_EDGES =
        led_reset_pkg::XTAL_SLOW_KHZ * 1000 / (2 * led_reset_pkg::FLASH_HZ)
) (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic [7:0] awaddr,
    input  wire logic       awvalid,
    output logic            awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0] wstrb,
    input  wire logic       wvalid,
    output logic            wready,
    output logic [1:0]      bresp,
    output logic            bvalid,
    input  wire logic       bready,
    input  wire logic [7:0] araddr,
    input  wire logic       arvalid,
    output logic            arready,
    output logic [31:0]     rdata,
    output logic [1:0]      rresp,
    output logic            rvalid,
    input  wire logic       rready,
    input  wire logic       crystal_in,
    input  wire logic       periphery_fault_in,
    input  wire logic       man_rx_in,
    input  wire logic       man_err_in,
    input  wire logic       comm_wd_expire,
    input  wire logic       data_strobe_n_in,
    output logic            data_strobe_n_out,
    output logic            data_strobe_n_oe_n,
    output logic            param_strobe_n_out,
    output logic            param_strobe_n_oe_n,
    output logic            green_indicator_pin_out,
    output logic            green_indicator_pin_oe_n,
    output logic            red_indicator_pin_out,
    output logic            red_indicator_pin_oe_n,
    output logic [3:0]      data_out,
    output logic            data_out_oe_n,
    output logic [3:0]      param_out,
    output logic            param_out_oe_n,
    output logic            fault_status_bit,
    output logic            dx_allowed
);
    import led_reset_pkg::*;

    // ------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------
    ctrl_s       ctrl_q;
    state_e      state_q;
    logic [31:0] seq_cnt_q;
    logic        por_q;
    logic        soft_cause_q;
    logic        block_q;
    logic        illegal_q;
    logic [31:0] ext_cnt_q;
    logic        ext_trig;
    logic        ext_state;
    logic        xs1_q, xs2_q, xs3_q;
    logic        x_edge;
    logic [9:0]  clkwd_cnt_q;
    logic        clk_dead_q;
    logic        clk_wd_trig;
    logic [7:0]  win_cnt_q;
    logic [7:0]  edge_cnt_q;
    logic        fast_q;
    logic [31:0] flash_cnt_q;
    logic        flash_q;
    logic        f1_q, f2_q;
    logic        man_q;
    logic [11:0] hold_cnt_q;
    logic        green_on, red_on;
    logic        green_oe_n_q, red_oe_n_q;
    logic [3:0]  data_q, param_q;
    logic        data_oe_n_q, param_oe_n_q;
    logic        wr_go, rd_go;
    logic        cmd_rst, cmd_bcast, wd_rst;
    logic        rst_req, rst_take, any_rst;
    logic        data_wr_ok;
    logic [31:0] init_lim;

    function automatic logic [31:0] read_word(input logic [7:0] a,
                                              input status_s s);
        read_word = 32'h0;
        unique case (a)
            OFS_CTRL:   read_word = {24'h0, ctrl_q};
            OFS_DATA:   read_word = {28'h0, data_q};
            OFS_PARAM:  read_word = {28'h0, param_q};
            OFS_STATUS: read_word = {24'h0, s};
            default:    read_word = 32'h0;
        endcase
    endfunction : read_word

    function automatic logic mapped(input logic [7:0] a);
        mapped = (a == OFS_CTRL) || (a == OFS_CMD) || (a == OFS_DATA) ||
                 (a == OFS_PARAM) || (a == OFS_STATUS);
    endfunction : mapped

    // ------------------------------------------------------------
    // Register bus
    // ------------------------------------------------------------
    assign wr_go   = awvalid && wvalid && !bvalid;
    assign awready = wr_go;
    assign wready  = wr_go;
    assign rd_go   = arvalid && !rvalid;
    assign arready = rd_go;

    assign cmd_rst   = wr_go && awaddr == OFS_CMD && wstrb[0] &&
                       wdata[CMD_RESET_BIT];
    assign cmd_bcast = wr_go && awaddr == OFS_CMD && wstrb[0] &&
                       wdata[CMD_BCAST_BIT];
    // Data writes refused while blocked or unaddressed
    assign data_wr_ok = dx_allowed;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp  <= RESP_OKAY;
        end else if (wr_go) begin
            bvalid <= 1'b1;
            if (!mapped(awaddr) || awaddr == OFS_STATUS ||
                (awaddr == OFS_DATA && !data_wr_ok))
                bresp <= RESP_SLVERR;
            else
                bresp <= RESP_OKAY;
        end else if (bready) begin
            bvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid <= 1'b0;
            rdata  <= 32'h0;
            rresp  <= RESP_OKAY;
        end else if (rd_go) begin
            rvalid <= 1'b1;
            rdata  <= read_word(araddr, {fast_q, ext_state, f2_q,
                          !state_q[0], block_q, dx_allowed, red_on,
                          green_on});
            rresp  <= mapped(araddr) ? RESP_OKAY : RESP_SLVERR;
        end else if (rready) begin
            rvalid <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            ctrl_q <= CTRL_RST;
        else if (wr_go && awaddr == OFS_CTRL && wstrb[0])
            ctrl_q <= wdata[7:0];
    end

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    assign wd_rst  = comm_wd_expire && ctrl_q.wd_en;
    assign rst_req = cmd_rst || cmd_bcast || wd_rst || ext_trig ||
                     clk_wd_trig || illegal_q;
    assign rst_take = rst_req && state_q != ST_STROBE;
    assign any_rst  = !aresetn || rst_take;
    // Budget includes strobe so total stays inside the limit
    assign init_lim = por_q ? POR_INIT_CYC : INIT_CYC - STB_CYC;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q   <= ST_INIT;
            seq_cnt_q <= 32'h0;
            por_q     <= 1'b1;
            illegal_q <= 1'b0;
        end else if (rst_take) begin
            state_q   <= ST_STROBE;
            seq_cnt_q <= 32'h0;
            por_q     <= 1'b0;
            illegal_q <= 1'b0;
        end else begin
            seq_cnt_q <= seq_cnt_q + 32'h1;
            unique case (state_q)
                ST_RUN: seq_cnt_q <= 32'h0;
                ST_STROBE: if (seq_cnt_q == STB_CYC - 1) begin
                    state_q   <= ST_INIT;
                    seq_cnt_q <= 32'h0;
                end
                ST_INIT: if (seq_cnt_q >= init_lim - 1) begin
                    state_q   <= ST_RUN;
                    seq_cnt_q <= 32'h0;
                end
                default: illegal_q <= 1'b1;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            soft_cause_q <= 1'b0;
        else if (rst_take)
            soft_cause_q <= cmd_rst || cmd_bcast || wd_rst;
    end

    // Parameter write clears block only once running
    always_ff @(posedge aclk) begin
        if (any_rst)
            block_q <= 1'b1;
        else if (wr_go && awaddr == OFS_PARAM && wstrb[0] &&
                 state_q == ST_RUN)
            block_q <= 1'b0;
    end

    assign dx_allowed = ctrl_q.addr != 5'h0 && !block_q &&
                        state_q == ST_RUN;

    // ------------------------------------------------------------
    // Data and parameter ports
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (any_rst) begin
            data_q      <= PORT_RST;
            data_oe_n_q <= 1'b1;
        end else if (wr_go && awaddr == OFS_DATA && wstrb[0] &&
                     data_wr_ok) begin
            data_q      <= wdata[3:0];
            data_oe_n_q <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (any_rst) begin
            param_q      <= PORT_RST;
            param_oe_n_q <= 1'b1;
        end else if (wr_go && awaddr == OFS_PARAM && wstrb[0] &&
                     state_q == ST_RUN) begin
            param_q      <= wdata[3:0];
            param_oe_n_q <= 1'b0;
        end
    end

    assign data_out       = data_q;
    assign data_out_oe_n  = data_oe_n_q;
    assign param_out      = param_q;
    assign param_out_oe_n = param_oe_n_q;
    // Both strobes share one source so they stay aligned
    assign data_strobe_n_out   = 1'b0;
    assign param_strobe_n_out  = 1'b0;
    assign data_strobe_n_oe_n  = state_q != ST_STROBE;
    assign param_strobe_n_oe_n = state_q != ST_STROBE;

    // ------------------------------------------------------------
    // External reset via strobe pin
    // ------------------------------------------------------------
    // Own strobe pulls the pin low, so it does not start a count;
    // a count under way runs on through it so the trigger fires once
    always_ff @(posedge aclk) begin
        if (!aresetn)
            ext_cnt_q <= 32'h0;
        else if (!data_strobe_n_in &&
                 (state_q != ST_STROBE || ext_cnt_q != 32'h0)) begin
            if (ext_cnt_q != EXT_RESET_CYC)
                ext_cnt_q <= ext_cnt_q + 32'h1;
        end else if (data_strobe_n_in)
            ext_cnt_q <= 32'h0;
    end

    assign ext_trig  = ext_cnt_q == EXT_RESET_CYC - 1;
    assign ext_state = ext_cnt_q == EXT_RESET_CYC;

    // ------------------------------------------------------------
    // Crystal detection and clock watchdog
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            xs1_q <= 1'b0;
            xs2_q <= 1'b0;
            xs3_q <= 1'b0;
        end else begin
            xs1_q <= crystal_in;
            xs2_q <= xs1_q;
            xs3_q <= xs2_q;
        end
    end

    assign x_edge = xs2_q && !xs3_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            win_cnt_q  <= 8'h0;
            edge_cnt_q <= 8'h0;
            fast_q     <= 1'b0;
        end else begin
            win_cnt_q <= win_cnt_q + 8'h1;
            if (win_cnt_q == 8'(DET_WIN_CYC - 1)) begin
                fast_q     <= edge_cnt_q > 8'(DET_THRESH);
                edge_cnt_q <= 8'h0;
            end else if (x_edge)
                edge_cnt_q <= edge_cnt_q + 8'h1;
        end
    end

    // One reset per loss; rearmed by the next oscillation
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            clkwd_cnt_q <= 10'h0;
            clk_dead_q  <= 1'b0;
        end else if (x_edge) begin
            clkwd_cnt_q <= 10'h0;
            clk_dead_q  <= 1'b0;
        end else if (clkwd_cnt_q == 10'(CLKWD_CYC)) begin
            clk_dead_q  <= 1'b1;
        end else begin
            clkwd_cnt_q <= clkwd_cnt_q + 10'h1;
        end
    end

    assign clk_wd_trig = clkwd_cnt_q == 10'(CLKWD_CYC) && !clk_dead_q;

    // ------------------------------------------------------------
    // Flash timebase
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (any_rst) begin
            flash_cnt_q <= 32'h0;
            flash_q     <= 1'b0;
        end else if (x_edge) begin
            if (flash_cnt_q >= (fast_q ? FLASH_FAST_EDGES
                                       : FLASH_SLOW_EDGES) - 1) begin
                flash_cnt_q <= 32'h0;
                flash_q     <= !flash_q;
            end else
                flash_cnt_q <= flash_cnt_q + 32'h1;
        end
    end

    // ------------------------------------------------------------
    // Fault input and Manchester forwarding
    // ------------------------------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            f1_q <= 1'b0;
            f2_q <= 1'b0;
        end else begin
            f1_q <= !periphery_fault_in;
            f2_q <= f1_q;
        end
    end

    assign fault_status_bit = f2_q;

    // Upstream decoder flags bad telegrams; timing is cleaned here
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            man_q      <= 1'b1;
            hold_cnt_q <= 12'h0;
        end else begin
            man_q <= man_rx_in;
            if (man_err_in)
                hold_cnt_q <= 12'(ERR_HOLD_CYC);
            else if (hold_cnt_q != 12'h0)
                hold_cnt_q <= hold_cnt_q - 12'h1;
        end
    end

    // ------------------------------------------------------------
    // Indicators
    // ------------------------------------------------------------
    always_comb begin
        green_on = 1'b0;
        red_on   = 1'b0;
        if (ext_state) begin
            red_on = 1'b1;
        end else if (state_q != ST_RUN) begin
            green_on = 1'b0;
        end else if (f2_q) begin
            green_on = flash_q;
            red_on   = !flash_q;
        end else if (ctrl_q.addr == 5'h0) begin
            green_on = flash_q;
            red_on   = flash_q;
        end else if (block_q && soft_cause_q && ctrl_q.wd_en) begin
            red_on = 1'b1;
        end else if (ctrl_q.comm_ok && !block_q) begin
            green_on = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            green_oe_n_q <= 1'b1;
            red_oe_n_q   <= 1'b1;
        end else if (ctrl_q.master) begin
            green_oe_n_q <= man_q || hold_cnt_q != 12'h0;
            red_oe_n_q   <= 1'b1;
        end else begin
            green_oe_n_q <= !green_on;
            red_oe_n_q   <= !red_on;
        end
    end

    assign green_indicator_pin_out  = 1'b0;
    assign red_indicator_pin_out    = 1'b0;
    assign green_indicator_pin_oe_n = green_oe_n_q;
    assign red_indicator_pin_oe_n   = red_oe_n_q;

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_red_master: assert property (
        ctrl_q.master && $past(ctrl_q.master) |-> red_indicator_pin_oe_n)
        else $error("red pin driven in master mode");
    chk_ext_red: assert property (
        ext_state && !ctrl_q.master |=>
            !red_indicator_pin_oe_n && green_indicator_pin_oe_n)
        else $error("external reset not shown as red");
    chk_fault_alt: assert property (
        !ext_state && state_q == ST_RUN && f2_q && !ctrl_q.master |=>
            green_indicator_pin_oe_n != red_indicator_pin_oe_n)
        else $error("fault not alternating");
    chk_addr0_block: assert property (
        ctrl_q.addr == 5'h0 |-> !dx_allowed)
        else $error("data exchange at address zero");
    chk_reset_ports: assert property (
        rst_take |=> data_out == 4'hf && data_out_oe_n &&
                     param_out == 4'hf && param_out_oe_n)
        else $error("ports not safe after reset");
    chk_strobe_pair: assert property (
        rst_take |=> (!data_strobe_n_oe_n && !param_strobe_n_oe_n)[*8])
        else $error("strobes not pulsed together");
    chk_block_set: assert property (
        rst_take |=> block_q && !dx_allowed)
        else $error("block flag not set by reset");
    chk_init_bound: assert property (
        state_q == ST_INIT && !por_q |-> seq_cnt_q < INIT_CYC)
        else $error("soft init too long");
    chk_clk_wd: assert property (
        clk_wd_trig && state_q != ST_STROBE |=> state_q == ST_STROBE)
        else $error("clock loss did not reset");
    chk_err_hold: assert property (
        ctrl_q.master && man_err_in ##1 ctrl_q.master[*1] |=>
            green_indicator_pin_oe_n[*8])
        else $error("output active after telegram error");

    cov_ext_reset: cover property (ext_trig);
    cov_param_unblock: cover property (block_q ##1 !block_q);
    cov_fault_flash: cover property (f2_q && flash_q ##1 !flash_q);

endmodule : status_led_and_reset_control

// ### src/led_reset_pkg.sv
package led_reset_pkg;

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_MHZ       = 40;
    localparam int unsigned CLK_KHZ       = 40000;
    localparam int unsigned EXT_RESET_MS  = 90;
    localparam int unsigned INIT_MS       = 2;
    localparam int unsigned POR_INIT_MS   = 30;
    localparam int unsigned CLKWD_US      = 20;
    localparam int unsigned STB_US        = 1;
    localparam int unsigned ERR_HOLD_US   = 50;
    localparam int unsigned FLASH_HZ      = 2;
    localparam int unsigned XTAL_FAST_KHZ = 16000;
    localparam int unsigned XTAL_SLOW_KHZ = 5330;
    localparam int unsigned CLKWD_CYC     = CLKWD_US * CLK_MHZ;
    localparam int unsigned STB_CYC       = STB_US * CLK_MHZ;
    localparam int unsigned ERR_HOLD_CYC  = ERR_HOLD_US * CLK_MHZ;
    localparam int unsigned DET_WIN_CYC   = 256;
    localparam int unsigned DET_THRESH    = 68;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_CMD    = 8'h04;
    localparam logic [7:0] OFS_DATA   = 8'h08;
    localparam logic [7:0] OFS_PARAM  = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    localparam int unsigned CMD_RESET_BIT = 0;
    localparam int unsigned CMD_BCAST_BIT = 1;
    localparam logic [7:0] CTRL_RST   = 8'h00;
    localparam logic [3:0] PORT_RST   = 4'hf;
    localparam logic [1:0] RESP_OKAY  = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [4:0] addr;
        logic       comm_ok;
        logic       wd_en;
        logic       master;
    } ctrl_s;

    typedef struct packed {
        logic       fast_xtal;
        logic       ext_state;
        logic       fault;
        logic       busy;
        logic       block;
        logic       dx_allowed;
        logic       red_on;
        logic       green_on;
    } status_s;

    typedef enum logic [2:0] {
        ST_RUN    = 3'b001,
        ST_STROBE = 3'b010,
        ST_INIT   = 3'b100
    } state_e;

endpackage : led_reset_pkg

// ### testbench/periph_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------
// Indicator pull-ups and crystal source
// ----------------------------------------------------------
module periph_model (
    input  wire logic aclk,
    input  wire logic xtal_en,
    input  wire logic green_oe_n,
    input  wire logic green_out,
    input  wire logic red_oe_n,
    input  wire logic red_out,
    output logic      crystal_in,
    output logic      green_level,
    output logic      red_level
);
    // Disabled crystal stands still, as a dead oscillator would
    initial crystal_in = 1'b0;
    always @(posedge aclk) begin
        if (xtal_en) crystal_in <= ~crystal_in;
    end
    // Released pin floats to the pull-up, LED dark
    assign green_level = green_oe_n ? 1'b1 : green_out;
    assign red_level   = red_oe_n ? 1'b1 : red_out;
endmodule : periph_model

// ### testbench/tb.sv
`timescale 1ns/10ps
// ----------------------------------------------------------
// Bench
// ----------------------------------------------------------
module tb;
    import led_reset_pkg::*;
    logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, xtal_en;
    logic awready, wready, bvalid, arready, rvalid, crystal_in;
    logic periphery_fault_in, man_rx_in, man_err_in, comm_wd_expire;
    logic data_strobe_n_in, data_strobe_n_out, data_strobe_n_oe_n;
    logic param_strobe_n_out, param_strobe_n_oe_n, green_indicator_pin_out;
    logic green_indicator_pin_oe_n, red_indicator_pin_out;
    logic red_indicator_pin_oe_n, data_out_oe_n, param_out_oe_n;
    logic fault_status_bit, dx_allowed, green_level, red_level, g;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [3:0]  wstrb, data_out, param_out;
    logic [1:0]  bresp, rresp, r;
    int          bad_count, compares, c;

    status_led_and_reset_control #(.EXT_RESET_CYC(200), .INIT_CYC(100),
        .POR_INIT_CYC(50), .FLASH_FAST_EDGES(4), .FLASH_SLOW_EDGES(3))
    i_status_led_and_reset_control (.aclk, .aresetn, .awaddr, .awvalid,
        .awready, .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready,
        .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready,
        .crystal_in, .periphery_fault_in, .man_rx_in, .man_err_in,
        .comm_wd_expire, .data_strobe_n_in, .data_strobe_n_out,
        .data_strobe_n_oe_n, .param_strobe_n_out, .param_strobe_n_oe_n,
        .green_indicator_pin_out, .green_indicator_pin_oe_n,
        .red_indicator_pin_out, .red_indicator_pin_oe_n, .data_out,
        .data_out_oe_n, .param_out, .param_out_oe_n, .fault_status_bit,
        .dx_allowed);

    periph_model i_periph_model (.aclk, .xtal_en,
        .green_oe_n(green_indicator_pin_oe_n),
        .green_out(green_indicator_pin_out),
        .red_oe_n(red_indicator_pin_oe_n), .red_out(red_indicator_pin_out),
        .crystal_in, .green_level, .red_level);

    initial begin
        aclk = 1'b0;
        forever #12.5 aclk = ~aclk;
    end

    task automatic stop_test;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : stop_test

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    // Bounded wait, sampled at the rising edge
    task automatic wt(ref logic s, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge aclk);
            n++;
        end while (s !== v && n < lim);
        if (s !== v) begin
            bad_count++;
            $display("mismatch %0t wait ran out", $time);
            stop_test();
        end
    endtask : wt

    task automatic wr(input logic [7:0] a, input logic [31:0] v,
                      input logic [1:0] er);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        wt(awready, 1'b1, 50);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        wt(bvalid, 1'b1, 50);
        chk(bresp, er);
    endtask : wr

    task automatic rd(input logic [7:0] a);
        araddr <= a;
        arvalid <= 1'b1;
        wt(arready, 1'b1, 50);
        arvalid <= 1'b0;
        wt(rvalid, 1'b1, 50);
        d = rdata;
        r = rresp;
    endtask : rd

    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done

    initial begin
        {awvalid, wvalid, arvalid, man_rx_in, man_err_in} = '0;
        {awaddr, araddr, wdata, comm_wd_expire, aresetn} = '0;
        {periphery_fault_in, data_strobe_n_in, xtal_en} = 3'b111;
        // Responses are always accepted at once
        {bready, rready, wstrb} = {2'b11, 4'hf};
        bad_count = 0;
        compares = 0;
        repeat (4) @(posedge aclk);
        aresetn <= 1'b1;
        repeat (2) @(posedge aclk);
        chk({data_out, data_out_oe_n, param_out_oe_n}, 6'h3f);
        chk({data_strobe_n_oe_n, param_strobe_n_oe_n}, 2'b11);
        // Crystal flag is only valid once the first window has closed
        repeat (260) @(posedge aclk);
        rd(OFS_STATUS);
        chk({d[7], d[4], d[3]}, 3'b101);
        done("power_on");
        wr(OFS_CTRL, 32'h2e, RESP_OKAY);
        wr(OFS_DATA, 32'h3, RESP_SLVERR);
        wr(OFS_PARAM, 32'h5, RESP_OKAY);
        wr(OFS_DATA, 32'h3, RESP_OKAY);
        repeat (2) @(posedge aclk);
        chk({param_out, data_out}, 8'h53);
        chk({green_level, red_level, dx_allowed}, 3'b011);
        rd(8'h14);
        chk(r, RESP_SLVERR);
        done("exchange");
        wr(OFS_CMD, 32'h1, RESP_OKAY);
        chk({data_strobe_n_oe_n, param_strobe_n_oe_n}, 2'b00);
        chk({data_out, data_out_oe_n}, 5'h1f);
        repeat (110) @(posedge aclk);
        chk({green_level, red_level}, 2'b10);
        wr(OFS_PARAM, 32'h5, RESP_OKAY);
        done("command_reset");
        comm_wd_expire <= 1'b1;
        @(posedge aclk);
        comm_wd_expire <= 1'b0;
        @(posedge aclk);
        chk({data_strobe_n_oe_n, param_out_oe_n}, 2'b01);
        repeat (110) @(posedge aclk);
        chk({green_level, red_level}, 2'b10);
        wr(OFS_PARAM, 32'h5, RESP_OKAY);
        wr(OFS_CMD, 32'h2, RESP_OKAY);
        chk({data_strobe_n_oe_n, param_strobe_n_oe_n}, 2'b00);
        repeat (110) @(posedge aclk);
        chk({green_level, red_level}, 2'b10);
        wr(OFS_PARAM, 32'h5, RESP_OKAY);
        done("watchdog_broadcast");
        periphery_fault_in <= 1'b0;
        repeat (4) @(posedge aclk);
        chk(fault_status_bit, 1'b1);
        chk(green_level ^ red_level, 1'b1);
        g = green_level;
        c = 0;
        repeat (40) begin
            @(posedge aclk);
            if (green_level !== g) c++;
            g = green_level;
        end
        chk(c >= 4 && c <= 6, 1'b1);
        periphery_fault_in <= 1'b1;
        done("fault");
        wr(OFS_CTRL, 32'h06, RESP_OKAY);
        repeat (3) @(posedge aclk);
        chk({green_level ^ red_level, dx_allowed}, 2'b00);
        wr(OFS_DATA, 32'h3, RESP_SLVERR);
        wr(OFS_CTRL, 32'h2e, RESP_OKAY);
        done("address_zero");
        data_strobe_n_in <= 1'b0;
        wt(red_level, 1'b0, 300);
        chk(green_level, 1'b1);
        data_strobe_n_in <= 1'b1;
        repeat (110) @(posedge aclk);
        wr(OFS_PARAM, 32'h5, RESP_OKAY);
        done("pin_reset");
        xtal_en <= 1'b0;
        wt(data_strobe_n_oe_n, 1'b0, 900);
        xtal_en <= 1'b1;
        repeat (110) @(posedge aclk);
        done("clock_loss");
        wr(OFS_CTRL, 32'h2f, RESP_OKAY);
        repeat (4) @(posedge aclk);
        chk({green_level, red_level}, 2'b01);
        man_rx_in <= 1'b1;
        repeat (4) @(posedge aclk);
        chk({green_level, red_level}, 2'b11);
        man_rx_in <= 1'b0;
        man_err_in <= 1'b1;
        @(posedge aclk);
        man_err_in <= 1'b0;
        repeat (4) @(posedge aclk);
        chk(green_level, 1'b1);
        done("master");
        stop_test();
    end
endmodule : tb
